// ---- psv_agu.sv ----
/*
  psv_agu: program-space address generator. builds 24-bit program
  addresses for fetch, table access and visibility data access, and
  counts the extra cycles a visibility access owes the core.
  assumes: single core_clk domain; all request inputs come from core
  logic on the same clock; the program memory consumes data_paddr.
*/
`timescale 1ns/100ps
`default_nettype none
module psv_agu
  import psv_pkg::*;
#(
  parameter logic [PC_W-1:0] RESET_PC = PC_RST
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               pc_advance,
  input  wire logic               pc_load,
  input  wire logic [PC_W-1:0]    pc_target,
  input  wire logic               pc_msb_use,
  input  wire logic               visibility_enable_bit,
  input  wire logic               table_page_wr,
  input  wire logic               visibility_page_wr,
  input  wire logic [PAGE_W-1:0]  page_wdata,
  input  wire psv_req_s           req,
  input  wire psv_rpt_s           rpt,
  input  wire logic [23:0]        prog_rdata,
  output logic      [PC_W-1:0]    pc,
  output logic      [PAGE_W-1:0]  table_page_reg,
  output logic      [PAGE_W-1:0]  visibility_page_reg,
  output logic      [PADDR_W-1:0] fetch_addr,
  output psv_paddr_s              data_paddr,
  output psv_src_e                data_src,
  output logic      [EA_W-1:0]    psv_rdata,
  output logic      [1:0]         extra_cycles,
  output logic                    stall
);

  // ---------------- page registers ----------------
  psv_page_reg #(
    .W   (PAGE_W),
    .RST (PAGE_RST)
  ) u_table_page (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .wr       (table_page_wr),
    .wdata    (page_wdata),
    .q        (table_page_reg)
  );

  psv_page_reg #(
    .W   (PAGE_W),
    .RST (PAGE_RST)
  ) u_vis_page (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .wr       (visibility_page_wr),
    .wdata    (page_wdata),
    .q        (visibility_page_reg)
  );

  // ---------------- program counter ----------------
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;

  // next pc: load or step by one word
  always_comb begin
    pc_nxt = pc_r;
    if (ce) begin
      if (pc_load) begin
        pc_nxt = pc_target;
      end else if (pc_advance && !stall) begin
        pc_nxt = pc_r + PC_STEP;
      end
    end
    pc_nxt[0] = 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_r <= RESET_PC;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign pc = pc_r;

  // fetch address: bit 23 zero, msb of pc masked unless special op
  always_comb begin
    fetch_addr = {1'b0, pc_r};
    if (!pc_msb_use) begin
      fetch_addr[PC_W-1] = 1'b0;
    end
    if (fetch_addr > USER_TOP) begin
      fetch_addr = USER_TOP;
    end
  end

  // ---------------- data access path ----------------
  logic psv_hit;
  logic [PADDR_W-1:0] tbl_addr;
  logic [PADDR_W-1:0] vis_addr;

  // visibility only for non-table accesses with ea msb and enable
  assign psv_hit = req.valid && !req.table_op
                   && req.ea[EA_MSB] && visibility_enable_bit;

  // table address: page above working register ea, all 24 bits
  assign tbl_addr = {table_page_reg, req.ea};

  // visibility address: bit 23 low, page, then ea low bits
  assign vis_addr = {1'b0, visibility_page_reg, req.ea[PSV_LOW_W-1:0]};

  // select address source and space flags
  always_comb begin
    data_src                = PSV_SRC_FETCH;
    data_paddr.valid        = 1'b0;
    data_paddr.addr         = fetch_addr;
    data_paddr.config_space = 1'b0;
    data_paddr.upper_lane   = 1'b0;
    data_paddr.x_space      = req.ea[XY_SPLIT];
    if (req.valid && req.table_op) begin
      data_src                = PSV_SRC_TABLE;
      data_paddr.valid        = 1'b1;
      data_paddr.addr         = tbl_addr;
      data_paddr.config_space = table_page_reg[TBL_SEL_BIT];
      data_paddr.upper_lane   = req.high_half;
    end else if (psv_hit) begin
      data_src                = PSV_SRC_PSV;
      data_paddr.valid        = 1'b1;
      data_paddr.addr         = vis_addr;
      data_paddr.x_space      = 1'b1;
    end
  end

  // ---------------- read data and cycle cost ----------------
  logic [EA_W-1:0] psv_rdata_r;
  logic [EA_W-1:0] psv_rdata_nxt;

  // only low 16 bits of a mapped word return; upper 8 trap if run
  always_comb begin
    psv_rdata_nxt = psv_rdata_r;
    if (ce && psv_hit) begin
      psv_rdata_nxt = prog_rdata[EA_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      psv_rdata_r <= '0;
    end else begin
      psv_rdata_r <= psv_rdata_nxt;
    end
  end

  assign psv_rdata = psv_rdata_r;

  logic [1:0] extra_now;

  psv_stall_calc u_cost (
    .psv_hit  (psv_hit),
    .short_op (req.short_op),
    .rpt      (rpt),
    .extra    (extra_now)
  );

  // stall counter: holds the pipeline for the access cycle plus the owed extra cycles
  logic [1:0] wait_r;
  logic [1:0] wait_nxt;
  logic       busy_r;
  logic       busy_nxt;

  always_comb begin
    wait_nxt = wait_r;
    busy_nxt = busy_r;
    if (ce) begin
      if (busy_r) begin
        wait_nxt = wait_r - EXTRA_ONE;
        busy_nxt = (wait_r != EXTRA_ONE);
      end else if (extra_now != EXTRA_ZERO) begin
        wait_nxt = extra_now;
        busy_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r <= EXTRA_ZERO;
      busy_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign stall        = busy_r || (extra_now != EXTRA_ZERO);
  assign extra_cycles = extra_now;

endmodule
`default_nettype wire

// ---- psv_pkg.sv ----
/*
  psv_pkg: shared constants and carrier types for the program-space
  address generator (fetch, table and visibility address build).
  assumes: included first in compile order, no other dependencies.
*/
package psv_pkg;

  localparam int PADDR_W   = 24;  // program address width
  localparam int PC_W      = 23;  // program counter width
  localparam int EA_W      = 16;  // data effective address width
  localparam int PAGE_W    = 8;   // page register width
  localparam int PSV_LOW_W = 15;  // data ea bits passed straight through
  localparam int TBL_SEL_BIT = 7; // table page bit choosing config space
  localparam int EA_MSB    = 15;  // data ea bit that selects visibility
  localparam int XY_SPLIT  = 15;  // data ea bit at fixed x/y split

  localparam logic [PC_W-1:0]    PC_RST      = 23'h00_0000;
  localparam logic [PC_W-1:0]    PC_STEP     = 23'h00_0002;
  localparam logic [PADDR_W-1:0] USER_TOP    = 24'h7F_FFFE;
  localparam logic [PAGE_W-1:0]  PAGE_RST    = 8'h00;
  localparam logic [1:0]         EXTRA_ZERO  = 2'h0;
  localparam logic [1:0]         EXTRA_ONE   = 2'h1;
  localparam logic [1:0]         EXTRA_TWO   = 2'h2;

  // address source of the current cycle
  typedef enum logic [2:0] {
    PSV_SRC_FETCH = 3'b001,
    PSV_SRC_TABLE = 3'b010,
    PSV_SRC_PSV   = 3'b100
  } psv_src_e;

  // data access request from the core
  typedef struct packed {
    logic            valid;
    logic [EA_W-1:0] ea;
    logic            table_op;   // table_read_op / table_write_op
    logic            high_half;  // table_read_high_op / table_write_high_op
    logic            short_op;   // mac prefetch, move, double_move_op
  } psv_req_s;

  // repeat loop context of the current instruction
  typedef struct packed {
    logic active;
    logic first;
    logic last;
    logic irq_exit;
    logic irq_resume;
  } psv_rpt_s;

  // program address result
  typedef struct packed {
    logic               valid;
    logic [PADDR_W-1:0] addr;
    logic               config_space;
    logic               x_space;
    logic               upper_lane;
  } psv_paddr_s;

endpackage

// ---- psv_page_reg.sv ----
/*
  psv_page_reg: one page register written by the core.
  assumes: core_clk domain, write strobe from same-clock logic.
*/
`timescale 1ns/100ps
`default_nettype none
module psv_page_reg
  import psv_pkg::*;
#(
  parameter int               W   = PAGE_W,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // next value on write
  always_comb begin
    q_nxt = q_r;
    if (ce && wr) begin
      q_nxt = wdata;
    end
  end

  // register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// ---- psv_stall_calc.sv ----
/*
  psv_stall_calc: extra cycles owed by a visibility access.
  assumes: request flags are same-clock logic from the core pipeline.
*/
`timescale 1ns/100ps
`default_nettype none
module psv_stall_calc
  import psv_pkg::*;
(
  input  wire logic     psv_hit,
  input  wire logic     short_op,
  input  wire psv_rpt_s rpt,
  output logic [1:0]    extra
);

  // cost table in and out of repeat loops
  always_comb begin
    extra = EXTRA_ZERO;
    if (psv_hit) begin
      if (!rpt.active) begin
        extra = short_op ? EXTRA_ONE : EXTRA_TWO;
      end else if (rpt.first || rpt.last || rpt.irq_exit || rpt.irq_resume) begin
        extra = EXTRA_TWO;
      end else begin
        extra = EXTRA_ZERO;
      end
    end
  end

endmodule
`default_nettype wire

// ---- psv_agu_asserts.sv ----
/*
  psv_agu_chk: port assertions for psv_agu.
  assumes: bound from the tb top file, ce held high.
*/
`timescale 1ns/100ps
`default_nettype none
module psv_agu_chk
  import psv_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               ce,
  input wire logic               pc_advance,
  input wire logic               pc_load,
  input wire logic               visibility_enable_bit,
  input wire psv_req_s           req,
  input wire psv_rpt_s           rpt,
  input wire logic [23:0]        prog_rdata,
  input wire logic [PC_W-1:0]    pc,
  input wire logic [PAGE_W-1:0]  table_page_reg,
  input wire logic [PAGE_W-1:0]  visibility_page_reg,
  input wire logic [PADDR_W-1:0] fetch_addr,
  input wire psv_paddr_s         data_paddr,
  input wire psv_src_e           data_src,
  input wire logic [EA_W-1:0]    psv_rdata,
  input wire logic [1:0]         extra_cycles,
  input wire logic               stall
);
  // visibility hit and costly loop iterations
  wire logic hit = req.valid & !req.table_op & req.ea[EA_MSB] & visibility_enable_bit;
  wire logic rpt_edge = rpt.first | rpt.last | rpt.irq_exit | rpt.irq_resume;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_pc_even: assert property (pc[0] == 1'b0) else $error("pc odd");
  a_pc_step: assert property (
    ce && pc_advance && !pc_load && !stall |=> pc == $past(pc) + PC_STEP) else $error("pc step");
  a_fetch_user: assert property (
    fetch_addr[23] == 1'b0 && fetch_addr <= USER_TOP) else $error("fetch range");
  a_tbl_addr: assert property (req.valid && req.table_op |->
    data_src == PSV_SRC_TABLE && data_paddr.addr == {table_page_reg, req.ea} &&
    data_paddr.config_space == table_page_reg[TBL_SEL_BIT]) else $error("table addr");
  a_vis_addr: assert property (hit |-> data_src == PSV_SRC_PSV &&
    data_paddr.x_space && data_paddr.addr == {1'b0, visibility_page_reg, req.ea[14:0]})
    else $error("vis addr");
  a_vis_gate: assert property (data_src == PSV_SRC_PSV |-> hit) else $error("vis gate");
  a_vis_data: assert property (
    hit && ce |=> psv_rdata == $past(prog_rdata[15:0])) else $error("vis data");
  a_short_cost: assert property (hit && ce && !rpt.active && req.short_op |->
    extra_cycles == EXTRA_ONE && stall ##1 stall ##1 !stall) else $error("short cost");
  a_long_cost: assert property (hit && ce && !rpt.active && !req.short_op |->
    extra_cycles == EXTRA_TWO && stall ##1 stall[*2] ##1 !stall) else $error("long cost");
  a_loop_edge: assert property (
    hit && rpt.active && rpt_edge |-> extra_cycles == EXTRA_TWO) else $error("loop edge");
  a_loop_fast: assert property (
    hit && rpt.active && !rpt_edge |-> extra_cycles == EXTRA_ZERO && !stall)
    else $error("loop fast");
  // main scenarios reached
  c_vis: cover property (hit && !rpt.active);
  c_loop: cover property (hit && rpt.active && !rpt_edge);
  c_tbl: cover property (req.valid && req.table_op && req.ea[EA_MSB]);
endmodule
`default_nettype wire

// ---- psv_pmem_model.sv ----
/*
  psv_pmem_model: program memory answering the address builder.
  assumes: combinational read of the word at data_paddr.addr.
*/
`timescale 1ns/100ps
`default_nettype none
module psv_pmem_model
  import psv_pkg::*;
(
  input wire psv_paddr_s  data_paddr,
  output logic [23:0]     prog_rdata
);
  // constant words carry an illegal opcode byte on top
  assign prog_rdata = {8'hFF, data_paddr.addr[15:0] ^ 16'h5A5A};
endmodule
`default_nettype wire

// ---- tb_psv_agu.sv ----
/*
  tb_psv_agu: directed bench for psv_agu.
  assumes: psv_pkg, checker and memory model compiled before.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_psv_agu
  import psv_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 ce = 1'b1;
  logic                 pc_advance = 1'b0;
  logic                 pc_load = 1'b0;
  logic                 pc_msb_use = 1'b0;
  logic                 visibility_enable_bit = 1'b0;
  logic                 table_page_wr = 1'b0;
  logic                 visibility_page_wr = 1'b0;
  logic [PC_W-1:0]      pc_target = '0;
  logic [PAGE_W-1:0]    page_wdata = '0;
  psv_req_s             req = '0;
  psv_rpt_s             rpt = '0;
  logic [23:0]          prog_rdata;
  logic [PC_W-1:0]      pc;
  logic [PAGE_W-1:0]    table_page_reg;
  logic [PAGE_W-1:0]    visibility_page_reg;
  logic [PADDR_W-1:0]   fetch_addr;
  psv_paddr_s           data_paddr;
  psv_src_e             data_src;
  logic [EA_W-1:0]      psv_rdata;
  logic [1:0]           extra_cycles;
  logic                 stall;
  int                   err_total = 0;
  int                   n_compared = 0;
  logic [4:0]           rp [5] = '{5'b11000, 5'b10100, 5'b10010, 5'b10001, 5'b10000};

  psv_agu uut (.core_clk, .rst, .ce, .pc_advance, .pc_load, .pc_target, .pc_msb_use,
    .visibility_enable_bit, .table_page_wr, .visibility_page_wr, .page_wdata, .req, .rpt,
    .prog_rdata, .pc, .table_page_reg, .visibility_page_reg, .fetch_addr, .data_paddr,
    .data_src, .psv_rdata, .extra_cycles, .stall);
  psv_pmem_model pmem (.data_paddr, .prog_rdata);

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  task chk(input logic [25:0] got, input logic [25:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one request cycle, checked at the falling edge
  task drive(input psv_req_s r, input psv_rpt_s p);
    @(posedge core_clk);
    req <= r;
    rpt <= p;
    @(negedge core_clk);
  endtask

  // visibility read with page 0x3c, then idle while the cost runs out
  task vis(input logic [15:0] ea, input logic s, input psv_rpt_s p, input logic [1:0] ex);
    drive({1'b1, ea, 1'b0, 1'b0, s}, p);
    chk(data_src, PSV_SRC_PSV);
    chk(data_paddr.addr, {1'b0, 8'h3C, ea[14:0]});
    chk(extra_cycles, ex);
    chk({data_paddr.valid, stall}, {1'b1, ex != EXTRA_ZERO});
    @(posedge core_clk);
    req <= '0;
    rpt <= '0;
    @(negedge core_clk);
    chk(psv_rdata, {1'b0, ea[14:0]} ^ 16'h5A5A);
    chk(stall, ex != EXTRA_ZERO);
    repeat (3) @(posedge core_clk);
  endtask

  // watchdog
  initial begin
    repeat (2000) @(posedge core_clk);
    err_total++;
    finish_test;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(pc, PC_RST);
    chk({table_page_reg, visibility_page_reg}, 16'h0000);
    @(posedge core_clk);
    table_page_wr <= 1'b1;
    page_wdata <= 8'h85;
    @(posedge core_clk);
    table_page_wr <= 1'b0;
    visibility_page_wr <= 1'b1;
    page_wdata <= 8'h3C;
    @(posedge core_clk);
    visibility_page_wr <= 1'b0;
    visibility_enable_bit <= 1'b1;
    @(negedge core_clk);
    chk({table_page_reg, visibility_page_reg}, 16'h853C);
    drive({1'b1, 16'h9234, 1'b1, 1'b1, 1'b0}, '0);
    chk(data_src, PSV_SRC_TABLE);
    chk({data_paddr.config_space, data_paddr.upper_lane, data_paddr.addr}, 26'h385_9234);
    vis(16'hC1F2, 1'b1, '0, EXTRA_ONE);
    vis(16'h8000, 1'b0, '0, EXTRA_TWO);
    for (int i = 0; i < 5; i++) begin
      vis(16'hFFFE, 1'b0, rp[i], (i < 4) ? EXTRA_TWO : EXTRA_ZERO);
    end
    visibility_enable_bit <= 1'b0;
    drive({1'b1, 16'hC000, 1'b0, 1'b0, 1'b0}, '0);
    chk({data_src, data_paddr.x_space}, {PSV_SRC_FETCH, 1'b1});
    drive({1'b1, 16'h7000, 1'b0, 1'b0, 1'b0}, '0);
    chk(data_paddr.x_space, 1'b0);
    @(posedge core_clk);
    req <= '0;
    pc_load <= 1'b1;
    pc_target <= 23'h40_0003;
    @(posedge core_clk);
    pc_load <= 1'b0;
    pc_advance <= 1'b1;
    @(posedge core_clk);
    pc_advance <= 1'b0;
    @(negedge core_clk);
    chk(pc, 23'h40_0004);
    chk(fetch_addr, 24'h00_0004);
    @(posedge core_clk);
    pc_msb_use <= 1'b1;
    @(negedge core_clk);
    chk(fetch_addr, 24'h40_0004);
    finish_test;
  end
endmodule

bind psv_agu psv_agu_chk chk (.core_clk, .rst, .ce, .pc_advance, .pc_load,
  .visibility_enable_bit, .req, .rpt, .prog_rdata, .pc, .table_page_reg,
  .visibility_page_reg, .fetch_addr, .data_paddr, .data_src, .psv_rdata,
  .extra_cycles, .stall);
`default_nettype wire
